// ### su3_defines.svh
// su3_defines.svh: addresses, field positions and counts of the serial unit
// assumes: included by the design module only
`ifndef SU3_DEFINES_SVH
`define SU3_DEFINES_SVH
`define SU3_ADDR_DATA  7'h05
`define SU3_ADDR_FMT   7'h1C
`define SU3_FMT_SL     0
`define SU3_FMT_CL     1
`define SU3_FMT_PS_LO  2
`define SU3_FMT_PS_HI  3
`define SU3_FMT_RST    4'h0
`define SU3_PAR_NONE   2'h0
`define SU3_PAR_ADD    2'h1
`define SU3_PAR_ODD    2'h2
`define SU3_ERR_PE     0
`define SU3_ERR_FE     1
`define SU3_ERR_OVE    2
`define SU3_TICK_LAST  4'hF
`define SU3_TICK_MID   4'h7
`define SU3_LEN7_LAST  4'h6
`define SU3_LEN8_LAST  4'h7
`define SU3_CSI_LAST   4'h7
`endif

// ### su3_peer.sv
// su3_peer.sv: far-side serial peer, a UART sender and a 3-wire slave partner
// assumes: clk_i is the unit clock; bits last 32 clocks (tick every other cycle)
`timescale 1ns/1ps
module su3_peer (
  input  wire logic clk_i,
  input  wire logic csi_i,
  input  wire logic sck_i,
  input  wire logic so_i,
  output logic      si_o
);
  logic [7:0] tx_byte;
  logic [7:0] cap;
  logic       uart_line;
  logic       si_csi;
  initial begin
    uart_line = 1'b1;
    si_csi    = 1'b1;
    tx_byte   = 8'h00;
    cap       = 8'h00;
  end
  // start low, data lsb first, parity, stop high; idle high after the frame
  task automatic send(input logic [11:0] b, input int k);
    for (int i = 0; i < k; i++) begin
      uart_line = b[i];
      repeat (32) @(posedge clk_i);
      #1;
    end
    uart_line = 1'b1;
  endtask : send
  // rotate with inversion so a finished transfer leaves the complement in tx_byte
  always @(negedge sck_i) if (csi_i) begin
    si_csi  <= tx_byte[7];
    tx_byte <= {tx_byte[6:0], ~tx_byte[7]};
  end
  always @(posedge sck_i) if (csi_i) cap <= {cap[6:0], so_i};
  assign si_o = csi_i ? si_csi : uart_line;
endmodule : su3_peer

// ### su3_pkg.sv
// su3_pkg.sv: state types of the serial unit
// assumes: su3_defines.svh is on the include path
package su3_pkg;
  typedef enum logic [2:0] {
    SU3_TX_IDLE  = 3'b000,
    SU3_TX_START = 3'b001,
    SU3_TX_DATA  = 3'b010,
    SU3_TX_PAR   = 3'b011,
    SU3_TX_STOP  = 3'b100
  } su3_tx_t;
  typedef enum logic [2:0] {
    SU3_RX_IDLE  = 3'b000,
    SU3_RX_START = 3'b001,
    SU3_RX_DATA  = 3'b010,
    SU3_RX_PAR   = 3'b011,
    SU3_RX_STOP  = 3'b100
  } su3_rx_t;
  typedef struct packed {
    logic [3:0] fmt;
    logic [7:0] thr;
    logic [7:0] rxb;
    logic [7:0] dbf;
    logic [2:0] err;
    logic       irq;
    logic       rx_full;
    su3_tx_t    tst;
    logic [7:0] tsh;
    logic [3:0] tbit;
    logic [3:0] ttk;
    logic       tpar;
    logic       txd;
    su3_rx_t    rst;
    logic [7:0] rsh;
    logic [3:0] rbit;
    logic [3:0] rtk;
    logic       rpar;
    logic       csi_busy;
    logic [3:0] ccnt;
    logic       sck_int;
    logic       sck_prev;
    logic       so;
  } su3_state_t;
endpackage : su3_pkg

// ### su3_serial_unit.sv
// su3_serial_unit.sv: UART / 3-wire serial unit with shared data address
// assumes: PUT/GET strobes and the data buffer come from the CPU core, one cycle each;
// BAUD16_TICK_I pulses at 16x the bit rate; pins are synchronous to CLK_I
`timescale 1ns/1ps
`include "su3_defines.svh"

// Behaviour
// - parity 00 none, 01 appended without receive check, 10 odd, 11 even
// - length bit clear gives 7-bit characters, set gives 8-bit
// - in 7-bit mode only holding bits 6..0 are sent
// - in 7-bit mode received bits fill 6..0, bit 7 reads zero
// - holding and receive buffer share address 05; writes hold, reads return buffer
// - PUT copies data buffer to holding; GET copies receive buffer to data buffer
// - writes to holding are ignored while a UART transmission runs
// - two modes, 3-wire and UART, sharing the same data registers
// - receive buffer is overwritten by every new character, read or not
// - stop bit select gives one stop bit when clear, two when set
// - reading the receive buffer clears the error status except a parity or framing bit the receiver sets in that cycle
// - 3-wire shifts out MSB first on falling clock, samples into LSB on rising
// - 3-wire sets the serial interrupt flag on the eighth rising clock edge
module su3_serial_unit
  import su3_pkg::*;
(
  input  wire logic       CLK_I,
  input  wire logic       RST_N_I,
  input  wire logic [6:0] PERIPH_ADDR_I,
  input  wire logic       PUT_I,
  input  wire logic       GET_I,
  input  wire logic [7:0] DBF_I,
  output logic      [7:0] DBF_O,
  input  wire logic       CLOCKED_SERIAL_ENABLE_I,
  input  wire logic       CSI_MASTER_I,
  input  wire logic       UART_TX_ENABLE_I,
  input  wire logic       UART_RX_ENABLE_I,
  input  wire logic       BAUD16_TICK_I,
  input  wire logic       IRQ_CLR_I,
  output logic            SERIAL_IRQ_FLAG_O,
  output logic      [2:0] RX_ERROR_STATUS_O,
  output logic            UART_TX_BUSY_O,
  input  wire logic       SERIAL_IN_PIN_I,
  output logic            SERIAL_OUT_PIN_O,
  output logic            SERIAL_OUT_PIN_OE_O,
  input  wire logic       SERIAL_CLOCK_PIN_I,
  output logic            SERIAL_CLOCK_PIN_O,
  output logic            SERIAL_CLOCK_PIN_OE_O
);

  su3_state_t s;
  su3_state_t next_s;
  logic       csi;
  logic       sck_now;
  logic       sck_rise;
  logic       sck_fall;
  logic       put_data;
  logic       get_data;
  logic [3:0] len_last;
  logic [1:0] ps;

  assign csi      = CLOCKED_SERIAL_ENABLE_I;
  assign ps       = s.fmt[`SU3_FMT_PS_HI:`SU3_FMT_PS_LO];
  assign len_last = s.fmt[`SU3_FMT_CL] ? `SU3_LEN8_LAST : `SU3_LEN7_LAST;
  assign put_data = PUT_I && (PERIPH_ADDR_I == `SU3_ADDR_DATA);
  assign get_data = GET_I && (PERIPH_ADDR_I == `SU3_ADDR_DATA);
  assign sck_now  = CSI_MASTER_I ? s.sck_int : SERIAL_CLOCK_PIN_I;
  assign sck_rise = !s.sck_prev && sck_now;
  assign sck_fall = s.sck_prev && !sck_now;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_s = s;
    next_s.sck_prev = sck_now;
    // flag clear first so that any set further down in the same cycle wins
    if (IRQ_CLR_I) begin
      next_s.irq = 1'b0;
    end
    // cpu side: reads first so that hardware sets below win over the clear
    if (GET_I) begin
      if (PERIPH_ADDR_I == `SU3_ADDR_DATA) begin
        next_s.dbf     = s.rxb;
        next_s.err     = 3'h0;
        next_s.rx_full = 1'b0;
      end else if (PERIPH_ADDR_I == `SU3_ADDR_FMT) begin
        next_s.dbf = {4'h0, s.fmt};
      end else begin
        next_s.dbf = 8'h00;
      end
    end
    if (PUT_I && PERIPH_ADDR_I == `SU3_ADDR_FMT) begin
      next_s.fmt = DBF_I[3:0];
    end
    if (put_data) begin
      if (UART_TX_ENABLE_I && !csi) begin
        if (s.tst == SU3_TX_IDLE) begin
          next_s.thr  = DBF_I;
          next_s.tsh  = DBF_I;
          next_s.tst  = SU3_TX_START;
          next_s.ttk  = 4'h0;
          next_s.tpar = (ps == `SU3_PAR_ODD);
        end
      end else begin
        next_s.thr = DBF_I;
        if (csi) begin
          next_s.tsh      = DBF_I;
          next_s.csi_busy = 1'b1;
          next_s.ccnt     = 4'h0;
        end
      end
    end
    // uart transmitter
    if (BAUD16_TICK_I && s.tst != SU3_TX_IDLE) begin
      next_s.ttk = s.ttk + 4'h1;
      if (s.ttk == `SU3_TICK_LAST) begin
        case (s.tst)
          SU3_TX_START: begin
            next_s.tst  = SU3_TX_DATA;
            next_s.tbit = 4'h0;
          end
          SU3_TX_DATA: begin
            next_s.tpar = s.tpar ^ s.tsh[0];
            next_s.tsh  = {1'b0, s.tsh[7:1]};
            next_s.tbit = s.tbit + 4'h1;
            if (s.tbit == len_last) begin
              next_s.tst  = (ps == `SU3_PAR_NONE) ? SU3_TX_STOP : SU3_TX_PAR;
              next_s.tbit = 4'h0;
            end
          end
          SU3_TX_PAR: begin
            next_s.tst  = SU3_TX_STOP;
            next_s.tbit = 4'h0;
          end
          SU3_TX_STOP: begin
            next_s.tbit = s.tbit + 4'h1;
            if (s.tbit[0] == s.fmt[`SU3_FMT_SL]) begin
              next_s.tst = SU3_TX_IDLE;
            end
          end
          default: next_s.tst = SU3_TX_IDLE;
        endcase
      end
    end
    case (next_s.tst)
      SU3_TX_START: next_s.txd = 1'b0;
      SU3_TX_DATA:  next_s.txd = next_s.tsh[0];
      SU3_TX_PAR:   next_s.txd = next_s.tpar;
      default:      next_s.txd = 1'b1;
    endcase
    // uart receiver
    if (!UART_RX_ENABLE_I || csi) begin
      next_s.rst = SU3_RX_IDLE;
    end else if (BAUD16_TICK_I) begin
      next_s.rtk = s.rtk + 4'h1;
      case (s.rst)
        SU3_RX_IDLE: begin
          next_s.rtk = 4'h0;
          if (!SERIAL_IN_PIN_I) begin
            next_s.rst = SU3_RX_START;
          end
        end
        SU3_RX_START: begin
          if (s.rtk == `SU3_TICK_MID) begin
            next_s.rst  = SERIAL_IN_PIN_I ? SU3_RX_IDLE : SU3_RX_DATA;
            next_s.rtk  = 4'h0;
            next_s.rbit = 4'h0;
            next_s.rpar = (ps == `SU3_PAR_ODD);
          end
        end
        SU3_RX_DATA: begin
          if (s.rtk == `SU3_TICK_LAST) begin
            next_s.rsh  = {SERIAL_IN_PIN_I, s.rsh[7:1]};
            next_s.rpar = s.rpar ^ SERIAL_IN_PIN_I;
            next_s.rbit = s.rbit + 4'h1;
            if (s.rbit == len_last) begin
              next_s.rst = (ps == `SU3_PAR_NONE) ? SU3_RX_STOP : SU3_RX_PAR;
            end
          end
        end
        SU3_RX_PAR: begin
          if (s.rtk == `SU3_TICK_LAST) begin
            next_s.rst = SU3_RX_STOP;
            if (ps[1] && (s.rpar ^ SERIAL_IN_PIN_I)) begin
              next_s.err[`SU3_ERR_PE] = 1'b1;
            end
          end
        end
        SU3_RX_STOP: begin
          if (s.rtk == `SU3_TICK_LAST) begin
            next_s.rst = SU3_RX_IDLE;
            next_s.rxb = s.fmt[`SU3_FMT_CL] ? s.rsh : {1'b0, s.rsh[7:1]};
            next_s.rx_full = 1'b1;
            next_s.irq     = 1'b1;
            if (s.rx_full && !get_data) begin
              next_s.err[`SU3_ERR_OVE] = 1'b1;
            end
            if (!SERIAL_IN_PIN_I) begin
              next_s.err[`SU3_ERR_FE] = 1'b1;
            end
          end
        end
        default: next_s.rst = SU3_RX_IDLE;
      endcase
    end
    // 3-wire transfer
    if (!csi) begin
      next_s.csi_busy = 1'b0;
    end
    if (!s.csi_busy || !csi) begin
      next_s.sck_int = 1'b1;
    end else if (CSI_MASTER_I && BAUD16_TICK_I) begin
      next_s.sck_int = !s.sck_int;
    end
    if (csi && s.csi_busy && sck_fall) begin
      next_s.so = s.tsh[7];
    end
    if (csi && s.csi_busy && sck_rise) begin
      next_s.tsh  = {s.tsh[6:0], SERIAL_IN_PIN_I};
      next_s.ccnt = s.ccnt + 4'h1;
      if (s.ccnt == `SU3_CSI_LAST) begin
        next_s.csi_busy = 1'b0;
        next_s.rxb      = {s.tsh[6:0], SERIAL_IN_PIN_I};
        next_s.rx_full  = 1'b1;
        next_s.irq      = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      s          <= '0;
      s.fmt      <= `SU3_FMT_RST;
      s.txd      <= 1'b1;
      s.sck_int  <= 1'b1;
      s.sck_prev <= 1'b1;
      s.so       <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign DBF_O                 = s.dbf;
  assign SERIAL_IRQ_FLAG_O     = s.irq;
  assign RX_ERROR_STATUS_O     = s.err;
  assign UART_TX_BUSY_O        = (s.tst != SU3_TX_IDLE);
  assign SERIAL_OUT_PIN_O      = csi ? s.so : s.txd;
  assign SERIAL_OUT_PIN_OE_O   = csi || UART_TX_ENABLE_I;
  assign SERIAL_CLOCK_PIN_O    = s.sck_int;
  assign SERIAL_CLOCK_PIN_OE_O = csi && CSI_MASTER_I;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  a_tx_write_block: assert property (put_data && s.tst != SU3_TX_IDLE
    |=> s.thr == $past(s.thr)) else $error("holding changed during transmit");
  a_get_returns_rxb: assert property (get_data
    |=> DBF_O == $past(s.rxb)) else $error("read did not return receive buffer");
  a_get_clears_err: assert property (get_data && s.rst == SU3_RX_IDLE
    |=> s.err == 3'h0) else $error("error status not cleared by read");
  a_rx7_msb_zero: assert property (s.rst == SU3_RX_STOP && !s.fmt[`SU3_FMT_CL]
    && BAUD16_TICK_I && s.rtk == `SU3_TICK_LAST |=> !s.rxb[7]) else $error("bit 7 not zero");
  a_start_low: assert property (s.tst == SU3_TX_START
    |-> !s.txd && $past(s.tst) != SU3_TX_DATA) else $error("start bit not low");
  a_stop_count: assert property (s.tst == SU3_TX_STOP && s.tbit == 4'h1
    |-> s.fmt[`SU3_FMT_SL] && s.txd) else $error("extra stop bit");
  a_no_par_state: assert property (s.tst == SU3_TX_PAR
    |-> ps != `SU3_PAR_NONE) else $error("parity sent with none selected");
  a_data_len: assert property (s.tst == SU3_TX_DATA
    |-> s.tbit <= len_last) else $error("too many data bits");
  a_csi_irq: assert property (csi && s.csi_busy && sck_rise && s.ccnt == `SU3_CSI_LAST
    |=> s.irq && !s.csi_busy) else $error("eighth edge did not raise flag");
  a_pin_route: assert property (csi
    |-> SERIAL_OUT_PIN_O == s.so && SERIAL_OUT_PIN_OE_O) else $error("data pin not routed");

  c_tx_frame: cover property (s.tst == SU3_TX_STOP ##1 s.tst == SU3_TX_IDLE);
  c_rx_char:  cover property (s.rst == SU3_RX_STOP ##1 s.rst == SU3_RX_IDLE);
  c_csi_done: cover property (s.csi_busy ##1 !s.csi_busy && s.irq);

endmodule : su3_serial_unit

// ### su3_serial_unit_tb.sv
// su3_serial_unit_tb.sv: self-checking bench of the serial unit
// assumes: su3_peer.sv and the design files are compiled first
`timescale 1ns/1ps
module su3_serial_unit_tb;
  import su3_pkg::*;
  localparam int D = 1;
  logic clk, rst_n, put, get, csi, mst, txen, rxen, tick, iclr;
  logic [6:0] addr;
  logic [7:0] din, dout;
  logic [2:0] err;
  logic irq, busy, so, so_oe, sin, sck_o, sck_oe, sck_in;
  int mismatches, check_count;
  su3_serial_unit uut (.CLK_I(clk), .RST_N_I(rst_n), .PERIPH_ADDR_I(addr), .PUT_I(put),
    .GET_I(get), .DBF_I(din), .DBF_O(dout), .CLOCKED_SERIAL_ENABLE_I(csi),
    .CSI_MASTER_I(mst), .UART_TX_ENABLE_I(txen), .UART_RX_ENABLE_I(rxen),
    .BAUD16_TICK_I(tick), .IRQ_CLR_I(iclr), .SERIAL_IRQ_FLAG_O(irq),
    .RX_ERROR_STATUS_O(err), .UART_TX_BUSY_O(busy), .SERIAL_IN_PIN_I(sin),
    .SERIAL_OUT_PIN_O(so), .SERIAL_OUT_PIN_OE_O(so_oe), .SERIAL_CLOCK_PIN_I(sck_in),
    .SERIAL_CLOCK_PIN_O(sck_o), .SERIAL_CLOCK_PIN_OE_O(sck_oe));
  su3_peer peer (.clk_i(clk), .csi_i(csi), .sck_i(mst ? sck_o : sck_in), .so_i(so), .si_o(sin));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) tick <= #D ~tick;
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : conclude
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic acc(input logic p, input logic g, input logic [6:0] a, input logic [7:0] d);
    @(posedge clk);
    #D;
    addr = a; put = p; get = g; din = d;
    @(posedge clk);
    #D;
    put = 1'b0; get = 1'b0;
  endtask : acc
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
    #D;
  endtask : wt
  // frame bits lsb first; pf flips parity, sv is the first stop level
  function automatic logic [11:0] frm(input logic [3:0] f, input logic [7:0] d,
                                      input logic pf, input logic sv, output int k);
    logic [7:0] m;
    m = f[1] ? d : {1'b0, d[6:0]};
    frm = 12'hFFF;
    frm[0] = 1'b0;
    for (int i = 0; i < 7 + f[1]; i++) frm[1 + i] = m[i];
    k = 8 + f[1];
    if (f[3:2] != 2'h0) begin
      frm[k] = ^m ^ (f[3:2] == 2'h2) ^ pf;
      k++;
    end
    frm[k] = sv;
    k += 1 + f[0];
  endfunction : frm
  ////////////////////////////////////////////////////////////////////////////////
  logic [3:0]  tx_fmt [6] = '{4'h0, 4'h3, 4'h4, 4'hB, 4'hE, 4'hD};
  logic [21:0] rx_tab [6] = '{{4'h2, 8'h5A, 1'b0, 1'b1, 8'h00}, {4'h0, 8'hC3, 1'b0, 1'b1, 8'h00},
    {4'hA, 8'h96, 1'b1, 1'b1, 8'h01}, {4'h6, 8'h96, 1'b1, 1'b1, 8'h00},
    {4'hE, 8'h69, 1'b0, 1'b1, 8'h00}, {4'h2, 8'h11, 1'b0, 1'b0, 8'h02}};
  logic [11:0] b;
  int k, n;
  initial begin
    rst_n = 1'b0; put = 1'b0; get = 1'b0; csi = 1'b0; mst = 1'b1; txen = 1'b1;
    rxen = 1'b1; tick = 1'b0; iclr = 1'b0; addr = 7'h00; din = 8'h00; sck_in = 1'b1;
    repeat (3) @(posedge clk);
    #D;
    rst_n = 1'b1;
    acc(0, 1, 7'h1C, 8'h00); chk(dout, 8'h00);
    acc(0, 1, 7'h10, 8'h00); chk(dout, 8'h00);
    acc(1, 0, 7'h1C, 8'h0B); acc(0, 1, 7'h1C, 8'h00); chk(dout, 8'h0B);
    $display("test registers done");
    foreach (tx_fmt[j]) begin
      acc(1, 0, 7'h1C, {4'h0, tx_fmt[j]});
      b = frm(tx_fmt[j], 8'hB5, 1'b0, 1'b1, k);
      acc(1, 0, 7'h05, 8'hB5);
      wt(17);
      for (int i = 0; i <= k; i++) begin
        if (i < k) begin
          chk({5'h0, so_oe, busy, so}, {5'h0, 2'h3, b[i]});
        end else begin
          chk({5'h0, so_oe, busy, so}, 8'h05);
        end
        if (i == 2) begin
          acc(1, 0, 7'h05, 8'h4A);
          wt(30);
        end else wt(32);
      end
    end
    $display("test uart transmit done");
    foreach (rx_tab[j]) begin
      acc(1, 0, 7'h1C, {4'h0, rx_tab[j][21:18]});
      b = frm(rx_tab[j][21:18], rx_tab[j][17:10], rx_tab[j][9], rx_tab[j][8], k);
      peer.send(b, k);
      wt(4);
      chk({5'h0, err}, rx_tab[j][7:0]);
      chk({7'h0, irq}, 8'h01);
      acc(0, 1, 7'h05, 8'h00);
      chk(dout, rx_tab[j][19] ? rx_tab[j][17:10] : {1'b0, rx_tab[j][16:10]});
      chk({5'h0, err}, 8'h00);
      iclr = 1'b1;
      wt(1);
      iclr = 1'b0;
      chk({7'h0, irq}, 8'h00);
    end
    $display("test uart receive done");
    chk({7'h0, sck_oe}, 8'h00);
    txen = 1'b0; rxen = 1'b0; csi = 1'b1;
    peer.tx_byte = 8'h3A;
    acc(1, 0, 7'h05, 8'hC6);
    n = 0;
    while (irq !== 1'b1 && n < 300) begin
      wt(1);
      n++;
    end
    wt(8);
    chk(peer.cap, 8'hC6);
    chk({4'h0, so_oe, irq, sck_oe, sck_o}, 8'h0F);
    acc(0, 1, 7'h05, 8'h00); chk(dout, 8'h3A);
    // slave: the bench drives the clock pin and the peer follows it
    iclr = 1'b1;
    wt(1);
    iclr = 1'b0;
    mst = 1'b0;
    peer.tx_byte = 8'hA5;
    acc(1, 0, 7'h05, 8'h69);
    for (int i = 0; i < 16; i++) begin
      sck_in = i[0];
      wt(3);
    end
    wt(2);
    chk(peer.cap, 8'h69);
    chk({4'h0, so_oe, irq, sck_oe, sck_o}, 8'h0D);
    acc(0, 1, 7'h05, 8'h00); chk(dout, 8'hA5);
    $display("test three wire done");
    conclude();
  end
  initial begin
    repeat (20000) @(posedge clk);
    mismatches++;
    conclude();
  end
endmodule : su3_serial_unit_tb
